// ===== bench/bdc_core_tb.sv
`timescale 1ns/1ps
module bdc_core_tb
	import bdc_pkg::*;
();
	logic        clk_i;
	logic        rst_i;
	logic [31:0] wb_adr_i;
	logic [31:0] wb_dat_i;
	logic [3:0]  wb_sel_i;
	logic        wb_we_i;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        ctl_line;
	logic        flow_pulse;
	logic        flow_nonzero;
	logic        dosing_line_o;
	logic        oe_n;
	logic        irq_o;
	logic        sw_go;
	logic [31:0] sw_len;
	int          err_total;
	int          n_tests;

	// A two-cycle millisecond keeps every timed window inside a short run.
	localparam int TICK_CYC = 2;

	bdc_core #(.TICK_CYCLES(TICK_CYC)) i_bdc_core (
		.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .control_line_i(ctl_line),
		.flow_pulse_i(flow_pulse), .flow_nonzero_i(flow_nonzero),
		.dosing_line_o(dosing_line_o), .control_line_oe_n_o(oe_n), .irq_o(irq_o)
	);

	bdc_switch_model i_bdc_switch_model (
		.clk_i(clk_i), .rst_i(rst_i), .go_i(sw_go), .len_i(sw_len), .level_o(ctl_line)
	);

	always #2.5 clk_i = ~clk_i;

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// One classic cycle; the request stands until ack is sampled high at a rising edge.
	task automatic wb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_adr_i <= {24'h0, a};
		wb_we_i  <= w;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (wb_ack_o !== 1'b1) begin
			err_total++;
			$display("mismatch ack expected 1 seen none");
			results();
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb_xfer(a, 1'b1, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb_xfer(a, 1'b0, 32'h0, q);
		chk($sformatf("reg %h", a), e, q);
	endtask

	task automatic pin(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask

	task automatic pulse(input int n);
		@(posedge clk_i);
		sw_go  <= 1'b1;
		sw_len <= n;
		@(posedge clk_i);
		sw_go  <= 1'b0;
		repeat (n + 30) @(posedge clk_i);
	endtask

	task automatic flow(input int n);
		flow_nonzero <= 1'b1;
		repeat (n) begin
			@(posedge clk_i);
			flow_pulse <= 1'b1;
			@(posedge clk_i);
			flow_pulse <= 1'b0;
		end
		@(posedge clk_i);
	endtask

	initial begin
		repeat (60000) @(posedge clk_i);
		err_total++;
		results();
	end

	initial begin
		logic [7:0]  ra [10];
		logic [31:0] rv [10];
		ra = '{ADDR_CTRL, ADDR_QTY, ADDR_CORR, ADDR_UNIT, ADDR_TMO, ADDR_CNT, ADDR_STAT,
			ADDR_IRQ, ADDR_MASK, ADDR_LINES};
		rv = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h1F4, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
		clk_i = 1'b0;
		rst_i = 1'b1;
		{wb_adr_i, wb_dat_i, wb_sel_i, wb_we_i, wb_cyc_i, wb_stb_i} = '0;
		flow_pulse = 1'b0;
		flow_nonzero = 1'b0;
		sw_go = 1'b0;
		sw_len = 32'h0;
		err_total = 0;
		n_tests = 0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 10; i++) begin
			rd(ra[i], rv[i]);
		end
		pin("oe_n", 1'b1, oe_n);
		rd(8'h30, 32'h0);
		wr(8'h30, 32'hFFFFFFFF);
		rd(8'h30, 32'h0);
		$display("test reset values done");
		for (int u = 0; u < 7; u++) begin
			wr(ADDR_UNIT, u);
			rd(ADDR_UNIT, u);
		end
		wr(ADDR_TMO, 32'h64);
		rd(ADDR_TMO, 32'h1F4);
		wr(ADDR_TMO, 32'h4E20);
		rd(ADDR_TMO, 32'h2710);
		wr(ADDR_TMO, 32'hBB8);
		rd(ADDR_TMO, 32'hBB8);
		$display("test unit and timeout done");
		wr(ADDR_QTY, 32'h000F4236);
		rd(ADDR_QTY, 32'h000F4236);
		wr(ADDR_CORR, 32'h0001869F);
		rd(ADDR_CORR, 32'h0001869F);
		wr(ADDR_CORR, 32'hFFFE7961);
		rd(ADDR_CORR, 32'hFFFE7961);
		rd(ADDR_IRQ, 32'h0);
		wr(ADDR_QTY, 32'h3E8);
		wr(ADDR_CORR, 32'hFFFFF830);
		rd(ADDR_CORR, 32'hFFFFFC22);
		rd(ADDR_IRQ, 32'h4);
		pin("irq masked", 1'b0, irq_o);
		wr(ADDR_MASK, 32'h4);
		rd(ADDR_MASK, 32'h4);
		pin("irq", 1'b1, irq_o);
		wr(ADDR_IRQ, 32'h4);
		rd(ADDR_IRQ, 32'h0);
		pin("irq cleared", 1'b0, irq_o);
		$display("test correction and interrupt done");
		wr(ADDR_LINES, 32'h3);
		rd(ADDR_LINES, 32'h3);
		pin("oe_n free", 1'b0, oe_n);
		wr(ADDR_CTRL, 32'h1);
		rd(ADDR_CTRL, 32'h1);
		rd(ADDR_LINES, 32'h0);
		pin("oe_n dosing", 1'b1, oe_n);
		wr(ADDR_LINES, 32'h2);
		rd(ADDR_LINES, 32'h0);
		wr(ADDR_CTRL, 32'h3);
		wr(ADDR_CTRL, 32'h1);
		rd(ADDR_STAT, 32'h0);
		pin("dosing short key", 1'b0, dosing_line_o);
		pulse(TICK_CYC * PULSE_MIN_MS / 2);
		rd(ADDR_STAT, 32'h0);
		pin("dosing short pulse", 1'b0, dosing_line_o);
		rd(ADDR_CNT, 32'h0);
		wr(ADDR_TMO, 32'h1F4);
		wr(ADDR_QTY, 32'h32);
		wr(ADDR_CORR, 32'hFFFFFFEC);
		rd(ADDR_CORR, 32'hFFFFFFEC);
		pulse(TICK_CYC * (RESET_MIN_MS + 200));
		rd(ADDR_CNT, 32'h32);
		pulse(TICK_CYC * 2 * PULSE_MIN_MS);
		rd(ADDR_STAT, 32'h1);
		pin("dosing run", 1'b1, dosing_line_o);
		rd(ADDR_IRQ, 32'h0);
		repeat (TICK_CYC * (TMO_MIN_MS + 50)) @(posedge clk_i);
		rd(ADDR_IRQ, 32'h2);
		wr(ADDR_IRQ, 32'h2);
		flow(1);
		rd(ADDR_CNT, 32'h28);
		pulse(TICK_CYC * 2 * PULSE_MIN_MS);
		rd(ADDR_STAT, 32'h0);
		pin("dosing stop", 1'b0, dosing_line_o);
		pulse(TICK_CYC * 2 * PULSE_MIN_MS);
		rd(ADDR_STAT, 32'h1);
		rd(ADDR_CNT, 32'h28);
		flow(2);
		rd(ADDR_STAT, 32'h2);
		rd(ADDR_CNT, 32'h14);
		rd(ADDR_IRQ, 32'h1);
		pin("dosing done", 1'b0, dosing_line_o);
		flow_nonzero <= 1'b0;
		pulse(TICK_CYC * (PULSE_MAX_MS + RESET_MIN_MS) / 2);
		rd(ADDR_STAT, 32'h2);
		wr(ADDR_CTRL, 32'h9);
		repeat (TICK_CYC * (KEY_HOLD_MS + 50)) @(posedge clk_i);
		wr(ADDR_CTRL, 32'h1);
		rd(ADDR_CNT, 32'h32);
		rd(ADDR_STAT, 32'h0);
		$display("test dosing cycle done");
		wr(ADDR_CTRL, 32'h0);
		rd(ADDR_LINES, 32'h0);
		pin("oe_n off", 1'b1, oe_n);
		wr(ADDR_LINES, 32'h1);
		rd(ADDR_LINES, 32'h1);
		pin("oe_n drive", 1'b0, oe_n);
		$display("test line ownership done");
		results();
	end
endmodule

// ===== bench/bdc_switch_model.sv
`timescale 1ns/1ps
module bdc_switch_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        go_i,
	input  wire logic [31:0] len_i,
	output logic             level_o
);
	logic [31:0] left_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			left_reg <= 32'h0;
		end else if (go_i && left_reg == 32'h0) begin
			left_reg <= len_i;
		end else if (left_reg != 32'h0) begin
			left_reg <= left_reg - 32'h1;
		end
	end

	// line actively driven low when idle
	assign level_o = (left_reg != 32'h0);
endmodule

// ===== src/bdc_core.sv
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - While enabled, dosing_line is push-pull output, control_line is input, locked.
// - Disabling sets both lines off, then they are free to configure.
// - Softkeys act only when held two seconds or more, on release.
// - Stopped state: control high 0.5 to 4 s starts dosing.
// - Running state: control high 0.5 to 4 s stops dosing.
// - Finished or stopped: reset request or high over 5 s reloads quantity.
// - Start drives dosing output high, counter falls while flow present.
// - Start after incomplete stop resumes from retained counter value.
// - Quantity up to 9999.9, one decimal, default zero.
// - Unit picks ml, L, m3, galUS, galUK, barrel, user; default liter.
// - Counter starts at quantity and stops at the negated correction value.
// - Correction within 999.99; nonpositive sum warns, correction becomes -(qty-0.1).
// - No flow for timeout (0.5 to 10 s, default 0.5) raises status.
// - Enable is persistent setting, disabled by default.
module bdc_core
	import bdc_pkg::*;
#(parameter int TICK_CYCLES = MS_CYCLES) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        control_line_i,
	input  wire logic        flow_pulse_i,
	input  wire logic        flow_nonzero_i,
	output logic             dosing_line_o,
	output logic             control_line_oe_n_o,
	output logic             irq_o
);

	localparam int CNT_W = 14;

	logic               ctl_sync;
	logic               ctl_fall;
	logic [CNT_W-1:0]   ctl_len;
	logic               tick;
	logic [17:0]        div_reg;
	logic               en_reg;
	logic [2:0]         keys_reg;
	logic [2:0]         key_prev_reg;
	logic [CNT_W-1:0]   key_cnt_reg;
	logic signed [23:0] qty_reg;
	logic signed [23:0] corr_reg;
	logic signed [23:0] corr_next;
	logic signed [23:0] cnt_reg;
	logic [2:0]         unit_reg;
	logic [CNT_W-1:0]   tmo_reg;
	logic [CNT_W-1:0]   idle_reg;
	logic [1:0]         lines_reg;
	logic [EV_WIDTH-1:0] stat_reg;
	logic [EV_WIDTH-1:0] mask_reg;
	logic [EV_WIDTH-1:0] ev;
	bdc_state_e         state_reg;
	logic               wr;
	logic               corr_bad;
	logic [31:0]        rd_data;
	logic               key_start;
	logic               key_stop;
	logic               key_reset;
	logic               pin_start;
	logic               pin_reset;
	logic               do_start;
	logic               do_stop;
	logic               do_reset;
	logic               at_end;

	bdc_sync u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (control_line_i),
		.q_o   (ctl_sync)
	);

	bdc_pulse_meter #(.CNT_W(CNT_W)) u_meter (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.tick_i  (tick),
		.level_i (ctl_sync && en_reg),
		.fall_o  (ctl_fall),
		.len_o   (ctl_len)
	);

	// Millisecond tick.
	assign tick = (div_reg == 18'(TICK_CYCLES - 1));
	always_ff @(posedge clk_i) begin
		if (rst_i || tick) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
	end

	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

	always_comb begin
		rd_data = '0;
		case (wb_adr_i[7:0])
			ADDR_CTRL:  rd_data = {30'h0, state_reg == BDC_RUNNING, en_reg};
			ADDR_QTY:   rd_data = 32'(qty_reg);
			ADDR_CORR:  rd_data = 32'(corr_reg);
			ADDR_UNIT:  rd_data = {29'h0, unit_reg};
			ADDR_TMO:   rd_data = {18'h0, tmo_reg};
			ADDR_CNT:   rd_data = 32'(cnt_reg);
			ADDR_STAT:  rd_data = {30'h0, state_reg};
			ADDR_IRQ:   rd_data = {29'h0, stat_reg};
			ADDR_MASK:  rd_data = {29'h0, mask_reg};
			ADDR_LINES: rd_data = {30'h0, lines_reg};
			default:    ;
		endcase
	end

	// Ack follows a request by one cycle; a write lands on the edge that sees ack high.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= rd_data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_reg <= 1'b0;
		end else if (wr && wb_adr_i[7:0] == ADDR_CTRL && wb_sel_i[0]) begin
			en_reg <= wb_dat_i[CTRL_EN];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lines_reg <= LINE_OFF;
		end else if (!en_reg && wr && wb_adr_i[7:0] == ADDR_LINES) begin
			lines_reg <= wb_dat_i[1:0];
		end else if (en_reg) begin
			lines_reg <= LINE_OFF;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			keys_reg     <= '0;
			key_prev_reg <= '0;
			key_cnt_reg  <= '0;
		end else begin
			if (wr && wb_adr_i[7:0] == ADDR_CTRL && wb_sel_i[0]) begin
				keys_reg <= wb_dat_i[CTRL_KRESET:CTRL_KSTART];
			end
			key_prev_reg <= keys_reg;
			if (keys_reg != key_prev_reg) begin
				key_cnt_reg <= '0;
			end else if (keys_reg != '0 && tick && key_cnt_reg != '1) begin
				key_cnt_reg <= key_cnt_reg + 1'b1;
			end
		end
	end

	assign key_start = keys_reg == '0 && key_prev_reg[0] && key_cnt_reg >= CNT_W'(KEY_HOLD_MS);
	assign key_stop  = keys_reg == '0 && key_prev_reg[1] && key_cnt_reg >= CNT_W'(KEY_HOLD_MS);
	assign key_reset = keys_reg == '0 && key_prev_reg[2] && key_cnt_reg >= CNT_W'(KEY_HOLD_MS);

	assign pin_start = ctl_fall && ctl_len > CNT_W'(PULSE_MIN_MS) && ctl_len < CNT_W'(PULSE_MAX_MS);
	assign pin_reset = ctl_fall && ctl_len > CNT_W'(RESET_MIN_MS);

	assign do_start = en_reg && state_reg == BDC_STOPPED && (key_start || pin_start);
	assign do_stop  = en_reg && state_reg == BDC_RUNNING && (key_stop || pin_start);
	assign do_reset = en_reg && state_reg != BDC_RUNNING && (key_reset || pin_reset);
	assign at_end   = cnt_reg + corr_reg <= 24'sd0;

	always_comb begin
		corr_bad  = 1'b0;
		corr_next = $signed(wb_dat_i[23:0]);
		if (corr_next > CORR_MAX) begin
			corr_next = CORR_MAX;
		end else if (corr_next < -CORR_MAX) begin
			corr_next = -CORR_MAX;
		end
		if (qty_reg + corr_next <= 24'sd0) begin
			corr_bad  = 1'b1;
			corr_next = QTY_STEP - qty_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			qty_reg  <= QTY_DEF;
			corr_reg <= QTY_DEF;
			unit_reg <= UNIT_DEF;
			tmo_reg  <= CNT_W'(TMO_DEF_MS);
		end else if (wr && state_reg != BDC_RUNNING) begin
			case (wb_adr_i[7:0])
				ADDR_QTY: begin
					qty_reg <= ($signed(wb_dat_i[23:0]) > QTY_MAX) ? QTY_MAX :
						($signed(wb_dat_i[23:0]) < 24'sd0) ? QTY_DEF : $signed(wb_dat_i[23:0]);
				end
				ADDR_CORR: corr_reg <= corr_next;
				ADDR_UNIT: unit_reg <= (wb_dat_i[2:0] > UNIT_MAX) ? UNIT_DEF : wb_dat_i[2:0];
				ADDR_TMO: begin
					tmo_reg <= (wb_dat_i < 32'(TMO_MIN_MS)) ? CNT_W'(TMO_MIN_MS) :
						(wb_dat_i > 32'(TMO_MAX_MS)) ? CNT_W'(TMO_MAX_MS) :
						wb_dat_i[CNT_W-1:0];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= BDC_STOPPED;
			cnt_reg   <= QTY_DEF;
		end else if (!en_reg) begin
			state_reg <= BDC_STOPPED;
		end else begin
			case (state_reg)
				BDC_STOPPED: begin
					if (do_start) begin
						state_reg <= BDC_RUNNING;
					end else if (do_reset) begin
						cnt_reg <= qty_reg;
					end
				end
				BDC_RUNNING: begin
					if (at_end) begin
						state_reg <= BDC_DONE;
					end else if (do_stop) begin
						state_reg <= BDC_STOPPED;
					end else if (flow_pulse_i) begin
						cnt_reg <= cnt_reg - QTY_STEP;
					end
				end
				BDC_DONE: begin
					if (do_reset) begin
						cnt_reg   <= qty_reg;
						state_reg <= BDC_STOPPED;
					end
				end
				default: state_reg <= BDC_STOPPED;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || state_reg != BDC_RUNNING || flow_nonzero_i) begin
			idle_reg <= '0;
		end else if (tick && idle_reg != '1) begin
			idle_reg <= idle_reg + 1'b1;
		end
	end

	assign ev[EV_DONE]    = state_reg == BDC_RUNNING && at_end;
	assign ev[EV_TIMEOUT] = tick && idle_reg == tmo_reg - 1'b1 && state_reg == BDC_RUNNING
		&& !flow_nonzero_i;
	assign ev[EV_WARN]    = wr && wb_adr_i[7:0] == ADDR_CORR && state_reg != BDC_RUNNING
		&& corr_bad;

	// Sticky status; a new event wins over a write-one clear.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_reg <= '0;
			mask_reg <= '0;
			irq_o    <= 1'b0;
		end else begin
			stat_reg <= ev | (stat_reg & ~((wr && wb_adr_i[7:0] == ADDR_IRQ) ?
				wb_dat_i[EV_WIDTH-1:0] : '0));
			if (wr && wb_adr_i[7:0] == ADDR_MASK) begin
				mask_reg <= wb_dat_i[EV_WIDTH-1:0];
			end
			irq_o <= |(stat_reg & mask_reg);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dosing_line_o       <= 1'b0;
			control_line_oe_n_o <= 1'b1;
		end else begin
			dosing_line_o       <= en_reg ? (state_reg == BDC_RUNNING && !at_end) : lines_reg[1];
			control_line_oe_n_o <= en_reg ? 1'b1 : !lines_reg[0];
		end
	end

	a_output_high: assert property (@(posedge clk_i) disable iff (rst_i)
		(en_reg && state_reg == BDC_RUNNING && !at_end) |=> dosing_line_o)
		else $error("dosing output not high while running");

	a_input_locked: assert property (@(posedge clk_i) disable iff (rst_i)
		en_reg |=> control_line_oe_n_o)
		else $error("control line driven while dosing enabled");

	a_lines_off: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(en_reg) |-> lines_reg == LINE_OFF)
		else $error("lines not off after disable");

	a_start_window: assert property (@(posedge clk_i) disable iff (rst_i)
		(en_reg && state_reg == BDC_STOPPED && pin_start) |=> state_reg == BDC_RUNNING)
		else $error("valid start pulse ignored");

	a_stop_window: assert property (@(posedge clk_i) disable iff (rst_i)
		(en_reg && state_reg == BDC_RUNNING && !at_end && pin_start) |=> state_reg == BDC_STOPPED)
		else $error("valid stop pulse ignored");

	a_reset_reload: assert property (@(posedge clk_i) disable iff (rst_i)
		(do_reset && state_reg == BDC_STOPPED && !do_start) |=> cnt_reg == $past(qty_reg))
		else $error("reset did not reload quantity");

	a_resume_keep: assert property (@(posedge clk_i) disable iff (rst_i)
		do_start |=> cnt_reg == $past(cnt_reg))
		else $error("start reloaded the counter");

	a_qty_limit: assert property (@(posedge clk_i) disable iff (rst_i)
		qty_reg <= QTY_MAX && qty_reg >= 24'sd0)
		else $error("quantity out of range");

	a_corr_sum: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(corr_reg) |-> qty_reg + corr_reg > 24'sd0)
		else $error("corrected target not positive");

	a_tmo_range: assert property (@(posedge clk_i) disable iff (rst_i)
		tmo_reg >= CNT_W'(TMO_MIN_MS) && tmo_reg <= CNT_W'(TMO_MAX_MS))
		else $error("timeout setting out of range");

	a_short_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
		(ctl_fall && ctl_len <= CNT_W'(PULSE_MIN_MS) && !key_start && !key_stop && !key_reset
			&& !at_end) |=> $stable(state_reg))
		else $error("short pulse changed state");

endmodule

// ===== src/bdc_pkg.sv
package bdc_pkg;

	localparam int CLK_HZ = 200_000_000;

	// Times in milliseconds.
	localparam int PULSE_MIN_MS  = 500;
	localparam int PULSE_MAX_MS  = 4000;
	localparam int RESET_MIN_MS  = 5000;
	localparam int KEY_HOLD_MS   = 2000;
	localparam int TMO_MIN_MS    = 500;
	localparam int TMO_MAX_MS    = 10000;
	localparam int TMO_DEF_MS    = 500;

	// Base tick is one millisecond.
	localparam int MS_CYCLES = CLK_HZ / 1000;

	// Quantities in hundredths of a unit.
	localparam logic signed [23:0] QTY_MAX   = 24'sd999990;
	localparam logic signed [23:0] CORR_MAX  = 24'sd99999;
	localparam logic signed [23:0] QTY_STEP  = 24'sd10;
	localparam logic signed [23:0] QTY_DEF   = 24'sd0;

	// Register byte offsets.
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_QTY    = 8'h04;
	localparam logic [7:0] ADDR_CORR   = 8'h08;
	localparam logic [7:0] ADDR_UNIT   = 8'h0C;
	localparam logic [7:0] ADDR_TMO    = 8'h10;
	localparam logic [7:0] ADDR_CNT    = 8'h14;
	localparam logic [7:0] ADDR_STAT   = 8'h18;
	localparam logic [7:0] ADDR_IRQ    = 8'h1C;
	localparam logic [7:0] ADDR_MASK   = 8'h20;
	localparam logic [7:0] ADDR_LINES  = 8'h24;

	// Control register fields.
	localparam int CTRL_EN     = 0;
	localparam int CTRL_KSTART = 1;
	localparam int CTRL_KSTOP  = 2;
	localparam int CTRL_KRESET = 3;

	// Event bits.
	localparam int EV_DONE    = 0;
	localparam int EV_TIMEOUT = 1;
	localparam int EV_WARN    = 2;
	localparam int EV_WIDTH   = 3;

	localparam logic [2:0] UNIT_DEF = 3'h1;
	localparam logic [2:0] UNIT_MAX = 3'h6;
	localparam logic [1:0] LINE_OFF = 2'h0;

	typedef enum logic [1:0] {
		BDC_STOPPED = 2'b00,
		BDC_RUNNING = 2'b01,
		BDC_DONE    = 2'b10
	} bdc_state_e;

endpackage

// ===== src/bdc_pulse_meter.sv
`timescale 1ns/1ps
module bdc_pulse_meter
	import bdc_pkg::*;
#(
	parameter int CNT_W = 14
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             tick_i,
	input  wire logic             level_i,
	output logic                  fall_o,
	output logic [CNT_W-1:0]      len_o
);

	logic             prev_reg;
	logic [CNT_W-1:0] cnt_reg;

	// Counts milliseconds of high time and reports it at the falling edge.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_reg <= 1'b0;
			cnt_reg  <= '0;
			fall_o   <= 1'b0;
			len_o    <= '0;
		end else begin
			prev_reg <= level_i;
			fall_o   <= prev_reg && !level_i;
			if (prev_reg && !level_i) begin
				len_o   <= cnt_reg;
				cnt_reg <= '0;
			end else if (level_i && tick_i && cnt_reg != '1) begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end

endmodule

// ===== src/bdc_sync.sv
`timescale 1ns/1ps
module bdc_sync
	import bdc_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic d_i,
	output logic      q_o
);

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			q_o    <= 1'b0;
		end else begin
			s1_reg <= d_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				q_o <= s3_reg;
			end
		end
	end

endmodule
